// ### dv/tb_pcm_programmer.sv
// tb_pcm_programmer: rate table, reset values, then one framed data word
// assumes the design's default sync words; one 200 MHz clock
`timescale 1ns/1ps
module tb_pcm_programmer;
   import pcm_prog_pkg::*;
   typedef struct {logic [2:0] sel; int ticks;} row_t;
   logic       ref_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [2:0] rate_sel = 3'h0;
   logic [7:0] level = 8'h5A;
   logic       comp_high;
   logic [7:0] weight_cmd;
   logic       clamp_out;
   logic       gate_duty;
   logic [9:0] row_drive;
   logic [9:0] col_drive;
   logic       ser_data;
   logic       data_clk;
   logic       word_sync;
   logic       overrun;
   logic [7:0] rx_word;
   logic       rx_done;
   int         n_fail = 0;
   int         total_checks = 0;
   int         n;
   int         n_duty = 0;
   int         n_clamp = 0;
   int         n_sync = 0;
   logic       mon_on = 1'b0;
   logic       s_ok = 1'b0;
   logic       p_duty, p_clamp, p_sync, p_ser;
   logic [9:0] p_col;
   // high phase of data_clk is half a bit: 4 << sel master ticks
   row_t       rows [2] = '{'{3'h0, 4}, '{3'h1, 8}};

   always #2.5 ref_clk = ~ref_clk;

   pcm_programmer u_pcm_programmer (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .rate_sel   (rate_sel),
      .comp_high  (comp_high),
      .weight_cmd (weight_cmd),
      .clamp_out  (clamp_out),
      .gate_duty  (gate_duty),
      .row_drive  (row_drive),
      .col_drive  (col_drive),
      .ser_data   (ser_data),
      .data_clk   (data_clk),
      .word_sync  (word_sync),
      .overrun    (overrun)
   );

   telemetry_rx_model u_telemetry_rx_model (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .data_clk   (data_clk),
      .ser_data   (ser_data),
      .weight_cmd (weight_cmd),
      .level      (level),
      .comp_high  (comp_high),
      .rx_word    (rx_word),
      .rx_done    (rx_done)
   );

   task automatic chk(input string name, input logic [33:0] exp,
                      input logic [33:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // master tick is 488.28 ref cycles; allow the accumulator's jitter
   function automatic logic in_rng(input int c, input int t);
      return (c >= t * 488 - 2) && (c <= t * 489 + 2);
   endfunction

   task automatic end_sim;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // first high phase after a rate change may be short, so skip one
   task automatic high_len(output int c);
      int k;
      c = 0;
      k = 0;
      while (data_clk !== 1'b0 && k < 40000) begin
         @(negedge ref_clk);
         k++;
      end
      while (data_clk !== 1'b1 && k < 40000) begin
         @(negedge ref_clk);
         k++;
      end
      while (data_clk === 1'b1 && k < 40000) begin
         @(negedge ref_clk);
         c++;
         k++;
      end
   endtask

   // event monitor, sampled at the falling edge where outputs are settled
   always @(negedge ref_clk) begin
      if (mon_on) begin
         chk("drive_idle", 0, gate_duty ? 20'h0 : {row_drive, col_drive});
         if (ser_data !== p_ser)
            chk("ser_edge_dclk", 1, data_clk);
         if (gate_duty && !p_duty) begin
            chk("conv_start_w", 8'h80, weight_cmd);
            chk("clamp_to_conv", 1, p_clamp && !clamp_out);
            chk("onehot", 1, $onehot(row_drive) && $onehot(col_drive));
            if (p_col !== 10'h000)
               chk("col_step", {p_col[8:0], p_col[9]}, col_drive);
            p_col = col_drive;
         end
         if (!gate_duty && p_duty) begin
            chk("conv_len", 1, in_rng(n_duty, 41));
            chk("hold_w", 0, weight_cmd);
         end
         if (!clamp_out && p_clamp)
            chk("clamp_len", 1, in_rng(n_clamp, 16));
         if (word_sync !== p_sync) begin
            if (s_ok)
               chk("sync_half", 1, in_rng(n_sync, 32));
            s_ok = 1'b1;
            n_sync = 0;
         end
      end
      if (reset_n !== 1'b1)
         p_col = 10'h000;
      n_duty = gate_duty ? n_duty + 1 : 0;
      n_clamp = clamp_out ? n_clamp + 1 : 0;
      n_sync++;
      p_duty = gate_duty;
      p_clamp = clamp_out;
      p_sync = word_sync;
      p_ser = ser_data;
   end

   // watchdog: a clean run takes about 110k cycles, so stop at 130k
   initial begin
      #650_000;
      n_fail++;
      end_sim();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      // bit-rate table
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         rate_sel <= rows[i].sel;
         high_len(n);
         chk("dclk_high", 1, in_rng(n, rows[i].ticks));
      end
      // reset in mid-run
      @(posedge ref_clk);
      reset_n <= 1'b0;
      rate_sel <= 3'h0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("reset_outs", {8'h00, 4'h0, 20'h0, 2'h1}, {weight_cmd, clamp_out,
          gate_duty, ser_data, word_sync, row_drive, col_drive, overrun,
          data_clk});
      @(posedge ref_clk);
      reset_n <= 1'b1;
      mon_on <= 1'b1;
      // sync word then the coder word of the analog level
      n = 0;
      while (rx_done !== 1'b1 && n < 115000) begin
         @(negedge ref_clk);
         n++;
      end
      chk("rx_done", 1, rx_done);
      chk("rx_word", level, rx_word);
      chk("overrun", 0, overrun);
      end_sim();
   end
endmodule

// ### dv/telemetry_rx_model.sv
// telemetry_rx_model: far-side receiver plus a comparator stand-in
// assumes nrz data moves while data_clk is high; bits taken at its fall
`timescale 1ns/1ps
module telemetry_rx_model #(
   parameter logic [7:0] SYNC_B = 8'h90
) (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       data_clk,
   input  wire logic       ser_data,
   input  wire logic [7:0] weight_cmd,
   input  wire logic [7:0] level,
   output logic            comp_high,
   output logic [7:0]      rx_word,
   output logic            rx_done
);
   logic       dclk_prev;
   logic [7:0] sh;
   logic       synced;
   logic [3:0] nbits;
   // comparator: a tried weight above the analog level is too large
   always @(posedge ref_clk) begin
      comp_high <= (weight_cmd > level);
   end
   // sampling at the clock fall keeps half a bit of margin either side
   always @(posedge ref_clk) begin
      if (reset_n !== 1'b1) begin
         dclk_prev <= 1'b1;
         sh        <= 8'h00;
         synced    <= 1'b0;
         nbits     <= 4'h0;
         rx_done   <= 1'b0;
         rx_word   <= 8'h00;
      end else begin
         dclk_prev <= data_clk;
         if (dclk_prev && !data_clk && !rx_done) begin
            sh <= {sh[6:0], ser_data};
            if (synced)
               nbits <= nbits + 4'h1;
            if (synced && nbits == 4'h7) begin
               rx_word <= {sh[6:0], ser_data};
               rx_done <= 1'b1;
            end
            if ({sh[6:0], ser_data} == SYNC_B)
               synced <= 1'b1;
         end
      end
   end
endmodule

// ### rtl/pcm_prog_pkg.sv
// pcm_prog_pkg: constants shared by the telemetry programmer and its fifo
// assumes a 200 MHz reference clock from which the master tick is derived
package pcm_prog_pkg;
   // reference and master clock rates (master held in tenths of a hertz)
   localparam int unsigned REF_HZ_X10    = 2_000_000_000;
   localparam int unsigned MASTER_HZ_X10 = 4_096_000;
   localparam int unsigned ACC_W         = 32;
   // fixed coder timing, in nanoseconds, as nominal figures
   localparam int unsigned T_SETTLE_NS = 30_000;
   localparam int unsigned T_DEC_NS    = 10_000;
   localparam int unsigned T_ACT_NS    = 2_500;
   // master-tick counts; all waits round down, the act wait never below one tick
   localparam int unsigned NS_X10K = 10_000_000;
   localparam int unsigned SETTLE_TICKS =
      (T_SETTLE_NS * (MASTER_HZ_X10 / 1000)) / NS_X10K;
   localparam int unsigned DEC_TICKS =
      (T_DEC_NS * (MASTER_HZ_X10 / 1000)) / NS_X10K;
   localparam int unsigned ACT_TICKS =
      ((T_ACT_NS * (MASTER_HZ_X10 / 1000)) / NS_X10K) < 1 ? 1 :
      (T_ACT_NS * (MASTER_HZ_X10 / 1000)) / NS_X10K;
   localparam int unsigned CONV_TICKS =
      SETTLE_TICKS + 7 * DEC_TICKS + ACT_TICKS;
   // divider and word geometry
   localparam int unsigned DIV_W       = 8;
   localparam int unsigned WORD_W      = 8;
   localparam int unsigned RING_W      = 10;
   localparam int unsigned RATE_MAX    = 6;
   localparam logic [8:0]  BASE_PERIOD = 9'h004;
   localparam int unsigned SYNC_TAP    = 5;
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam logic [2:0]  BIT_CLAMP_END = 3'h1;
   localparam logic [2:0]  BIT_PRE_CONV  = 3'h1;
   localparam logic [7:0]  MSB_WEIGHT  = 8'h80;
   localparam logic [3:0]  SHIFT_LEN   = 4'h7;
   localparam int unsigned FIFO_DEPTH  = 8;
   // timer width for the coder phases
   localparam int unsigned PH_W = 6;
   // coder sequence states
   typedef enum logic [2:0] {
      CV_IDLE, CV_SETTLE, CV_WAIT, CV_ACT, CV_HOLD
   } conv_state_t;
endpackage

// ### rtl/pcm_programmer.sv
// pcm_programmer: timing, frame and output logic of a pcm telemetry encoder
// assumes comparator and analog gates outside; all inputs synchronous
`timescale 1ns/1ps
module pcm_programmer
   import pcm_prog_pkg::*;
#(
   parameter logic [7:0] SYNC_WORD_A = 8'hEB, // frame sync, first word
   parameter logic [7:0] SYNC_WORD_B = 8'h90  // frame sync, second word
) (
   input  wire logic                           ref_clk,
   input  wire logic                           reset_n,
   input  wire logic [2:0]                     rate_sel,
   input  wire logic                           comp_high,
   output logic      [pcm_prog_pkg::WORD_W-1:0] weight_cmd,
   output logic                                clamp_out,
   output logic                                gate_duty,
   output logic      [pcm_prog_pkg::RING_W-1:0] row_drive,
   output logic      [pcm_prog_pkg::RING_W-1:0] col_drive,
   output logic                                ser_data,
   output logic                                data_clk,
   output logic                                word_sync,
   output logic                                overrun
);
   import pcm_prog_pkg::*;

   logic [ACC_W-1:0]  acc_reg;
   logic              master_tick;
   logic [DIV_W-1:0]  div_reg;
   logic [2:0]        rate_eff;
   logic [8:0]        period_w;
   logic [DIV_W-1:0]  tap_mask;
   logic              rate_tick;
   logic              half_reg;
   logic              bit_start;
   logic              mid_bit;
   logic [2:0]        bit_reg;
   logic [RING_W-1:0] row_reg;
   logic [RING_W-1:0] col_reg;
   conv_state_t       conv_reg;
   logic [PH_W-1:0]   ph_reg;
   logic [WORD_W-1:0] sar_reg;
   logic [WORD_W-1:0] trial_reg;
   logic              comp_reg;
   logic [WORD_W-1:0] code_reg;
   logic [WORD_W-1:0] word_reg;
   logic              pend_reg;
   logic              fifo_in_ready;
   logic [WORD_W-1:0] fifo_out_data;
   logic              fifo_out_valid;
   logic              fifo_pop;
   logic [WORD_W-1:0] sh_reg;
   logic [3:0]        sh_cnt_reg;
   logic              ser_reg;
   logic              clamp_reg;
   logic              sync_reg;
   logic              ovr_reg;
   logic              first_word;
   logic              second_word;

   // master tick by fractional accumulation of 409.6 kHz over 200 MHz
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         acc_reg <= '0;
      end else if (acc_reg + MASTER_HZ_X10 >= REF_HZ_X10) begin
         acc_reg <= ACC_W'(acc_reg + MASTER_HZ_X10 - REF_HZ_X10);
      end else begin
         acc_reg <= ACC_W'(acc_reg + MASTER_HZ_X10);
      end
   end
   assign master_tick = (acc_reg + MASTER_HZ_X10 >= REF_HZ_X10);

   // free-running eight-stage divider on the master tick
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div_reg <= '0;
      end else if (master_tick) begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // select a divider tap; codes above the slowest rate clamp to it
   // bit-rate clock period is 4 << sel master ticks (twice the data rate)
   assign rate_eff  = (rate_sel > 3'(RATE_MAX)) ? 3'(RATE_MAX) : rate_sel;
   assign period_w  = BASE_PERIOD << rate_eff;
   assign tap_mask  = DIV_W'(period_w - 9'h001);
   assign rate_tick = master_tick && ((div_reg & tap_mask) == tap_mask);

   // divide-by-two stage gives the data rate; low half is the bit's first
   assign bit_start = rate_tick && half_reg;
   assign mid_bit   = rate_tick && !half_reg;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         half_reg <= 1'b1;
      end else if (rate_tick) begin
         half_reg <= !half_reg;
      end
   end

   // three-stage bit counter, eight bit times per word
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         bit_reg <= BIT_LAST;
      end else if (bit_start) begin
         bit_reg <= bit_reg + 1'b1;
      end
   end

   // column ring steps each word, row ring each ten words: 100-word frame
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         col_reg <= RING_W'(1);
         row_reg <= RING_W'(1);
      end else if (bit_start && bit_reg == BIT_LAST) begin
         col_reg <= {col_reg[RING_W-2:0], col_reg[RING_W-1]};
         if (col_reg[RING_W-1]) begin
            row_reg <= {row_reg[RING_W-2:0], row_reg[RING_W-1]};
         end
      end
   end

   // clamp over bits one and two; registered so it lines up with bit_reg
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         clamp_reg <= 1'b0;
      end else if (bit_start) begin
         clamp_reg <= (bit_reg == BIT_LAST) || (bit_reg == 3'h0);
      end
   end

   // fixed-time coder sequence, paced by master ticks only so that
   // its length never stretches with slower bit rates
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         conv_reg  <= CV_IDLE;
         ph_reg    <= '0;
         sar_reg   <= '0;
         trial_reg <= '0;
         comp_reg  <= 1'b0;
      end else if (bit_start && bit_reg == BIT_PRE_CONV) begin
         conv_reg  <= CV_SETTLE;
         ph_reg    <= PH_W'(SETTLE_TICKS - 1);
         sar_reg   <= MSB_WEIGHT;
         trial_reg <= MSB_WEIGHT;
      end else if (master_tick) begin
         case (conv_reg)
            CV_SETTLE, CV_WAIT: begin
               if (ph_reg == '0) begin
                  comp_reg <= comp_high;
                  conv_reg <= CV_ACT;
                  ph_reg   <= PH_W'(ACT_TICKS - 1);
               end else begin
                  ph_reg <= ph_reg - 1'b1;
               end
            end
            CV_ACT: begin
               if (ph_reg == '0) begin
                  // drop the tried weight if it overshot, enable the next
                  sar_reg <= (comp_reg ? (sar_reg & ~trial_reg) : sar_reg)
                             | (trial_reg >> 1);
                  trial_reg <= trial_reg >> 1;
                  ph_reg    <= PH_W'(DEC_TICKS - ACT_TICKS - 1);
                  conv_reg  <= (trial_reg[0]) ? CV_HOLD : CV_WAIT;
               end else begin
                  ph_reg <= ph_reg - 1'b1;
               end
            end
            CV_HOLD: begin
               conv_reg <= CV_HOLD;
            end
            CV_IDLE: begin
               conv_reg <= CV_IDLE;
            end
            default: begin
               conv_reg <= CV_IDLE;
            end
         endcase
      end
   end

   // code held once the last decision lands; weights stay off until next
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         code_reg <= '0;
      end else if (master_tick && conv_reg == CV_ACT && ph_reg == '0
                   && trial_reg[0]) begin
         code_reg <= comp_reg ? (sar_reg & ~trial_reg) : sar_reg;
      end
   end

   // weights and gate duty live only in the conversion, which saves power
   assign weight_cmd = (conv_reg == CV_IDLE || conv_reg == CV_HOLD) ?
                       '0 : sar_reg;
   assign gate_duty  = (conv_reg != CV_IDLE && conv_reg != CV_HOLD);
   assign row_drive  = gate_duty ? row_reg : '0;
   assign col_drive  = gate_duty ? col_reg : '0;
   assign clamp_out  = clamp_reg;

   // word multiplexer: sync constants on words one and two, else the code
   assign first_word  = row_reg[0] && col_reg[0];
   assign second_word = row_reg[0] && col_reg[1];
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         word_reg <= '0;
         pend_reg <= 1'b0;
      end else if (mid_bit && bit_reg == BIT_LAST) begin
         pend_reg <= 1'b1;
         word_reg <= first_word  ? SYNC_WORD_A :
                     second_word ? SYNC_WORD_B : code_reg;
      end else if (pend_reg && fifo_in_ready) begin
         pend_reg <= 1'b0;
      end
   end

   // a word still waiting when the next arrives is lost: flag it sticky
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ovr_reg <= 1'b0;
      end else if (mid_bit && bit_reg == BIT_LAST && pend_reg) begin
         ovr_reg <= 1'b1;
      end
   end
   assign overrun = ovr_reg;

   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .in_data   (word_reg),
      .in_valid  (pend_reg),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop)
   );

   // output shifter moves only on mid-bit ticks, half a bit after counters
   assign fifo_pop = mid_bit && sh_cnt_reg == '0 && fifo_out_valid;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sh_reg     <= '0;
         sh_cnt_reg <= '0;
         ser_reg    <= 1'b0;
      end else if (fifo_pop) begin
         ser_reg    <= fifo_out_data[WORD_W-1];
         sh_reg     <= {fifo_out_data[WORD_W-2:0], 1'b0};
         sh_cnt_reg <= SHIFT_LEN;
      end else if (mid_bit && sh_cnt_reg != '0) begin
         ser_reg    <= sh_reg[WORD_W-1];
         sh_reg     <= {sh_reg[WORD_W-2:0], 1'b0};
         sh_cnt_reg <= sh_cnt_reg - 1'b1;
      end
   end
   assign ser_data = ser_reg;
   assign data_clk = half_reg;

   // fixed-rate square wave at the high-speed word period
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sync_reg <= 1'b0;
      end else begin
         sync_reg <= div_reg[SYNC_TAP];
      end
   end
   assign word_sync = sync_reg;

   // helper: master ticks from conversion start to the hold state
   logic [7:0] conv_len_reg;
   always_ff @(posedge ref_clk) begin
      if (!reset_n || (bit_start && bit_reg == BIT_PRE_CONV)) begin
         conv_len_reg <= '0;
      end else if (master_tick && conv_reg != CV_HOLD
                   && conv_reg != CV_IDLE) begin
         conv_len_reg <= conv_len_reg + 1'b1;
      end
   end

   property p_master_spacing;
      @(posedge ref_clk) disable iff (!reset_n)
      master_tick |=> !master_tick [*8];
   endproperty
   a_master_spacing: assert property (p_master_spacing)
      else $error("master ticks too close");

   property p_clamp;
      @(posedge ref_clk) disable iff (!reset_n)
      (bit_start && bit_reg == BIT_LAST) |=> clamp_out && !gate_duty;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("clamp missing in bit one");

   property p_conv_start;
      @(posedge ref_clk) disable iff (!reset_n)
      (bit_start && bit_reg == BIT_PRE_CONV) |=>
         conv_reg == CV_SETTLE && weight_cmd == MSB_WEIGHT && !clamp_out;
   endproperty
   a_conv_start: assert property (p_conv_start)
      else $error("conversion did not start at bit three");

   property p_conv_len;
      @(posedge ref_clk) disable iff (!reset_n)
      (conv_reg != CV_HOLD) ##1 (conv_reg == CV_HOLD) |->
         conv_len_reg == 8'(CONV_TICKS);
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion length wrong");

   property p_weights_off;
      @(posedge ref_clk) disable iff (!reset_n)
      conv_reg == CV_HOLD |-> weight_cmd == '0 && !gate_duty;
   endproperty
   a_weights_off: assert property (p_weights_off)
      else $error("weights on after last decision");

   property p_rings;
      @(posedge ref_clk) disable iff (!reset_n)
      $onehot(row_reg) && $onehot(col_reg);
   endproperty
   a_rings: assert property (p_rings)
      else $error("frame ring not one-hot");

   property p_gate;
      @(posedge ref_clk) disable iff (!reset_n)
      (row_drive != '0 || col_drive != '0) |-> gate_duty && !clamp_out;
   endproperty
   a_gate: assert property (p_gate)
      else $error("gate driven outside conversion");

   property p_sync_word;
      @(posedge ref_clk) disable iff (!reset_n)
      (mid_bit && bit_reg == BIT_LAST && first_word) |=>
         word_reg == SYNC_WORD_A && pend_reg;
   endproperty
   a_sync_word: assert property (p_sync_word)
      else $error("sync word not loaded on word one");

   property p_shift_phase;
      @(posedge ref_clk) disable iff (!reset_n)
      $changed(ser_data) |-> $past(mid_bit);
   endproperty
   a_shift_phase: assert property (p_shift_phase)
      else $error("serial data moved off the mid-bit tick");

   c_conv_done: cover property (@(posedge ref_clk) disable iff (!reset_n)
      conv_reg == CV_HOLD);
   c_frame_wrap: cover property (@(posedge ref_clk) disable iff (!reset_n)
      bit_start && row_reg[RING_W-1] && col_reg[RING_W-1]);
   c_word_out: cover property (@(posedge ref_clk) disable iff (!reset_n)
      fifo_pop);
endmodule

// ### rtl/word_fifo.sv
// word_fifo: synchronous fifo between the word multiplexer and output shifter
// assumes a single clock and synchronous active-low reset
`timescale 1ns/1ps
module word_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // honest flags straight from the occupancy count
   assign in_ready  = (count_reg != FULL_CNT);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage; no reset needed since empty words are never presented
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_IX) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_IX) ? '0 : rd_ptr_reg + 1'b1;
         end
      end
   end

   // occupancy
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (push && !pop) begin
         count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
         count_reg <= count_reg - 1'b1;
      end
   end
endmodule
